/* File: design/uadm_pkg.sv */
package uadm_pkg;
  // unit address layout
  localparam int UADM_UA_W = 8;
  localparam int UADM_MOD_W = 2;
  localparam int UADM_LS_AW = 10;
  localparam int UADM_LS_DEPTH = 1024;
  localparam int UADM_DATA_W = 64;
  localparam int UADM_PAR_W = 8;
  localparam int UADM_WORD_W = 72;
  localparam int UADM_NSEL = 4;
  localparam int UADM_WORDS_PER_DEV = 4;
  localparam int UADM_NDEV = 256;
  localparam int UADM_MUX_DEVS = 192;
  // field positions, address msb is bit 7
  localparam int UADM_SEL_HI = 7;
  localparam int UADM_SEL_LO = 6;
  localparam int UADM_BURST_HI = 5;
  localparam int UADM_BURST_LO = 4;
  localparam int UADM_DEV_HI = 3;
  localparam int UADM_DEV_LO = 0;
  localparam int UADM_CU_BIT = 3;
  localparam logic [7:0] UADM_MUX_LAST = 8'hbf;
  localparam logic [7:0] UADM_SEL_FIRST = 8'hc0;
  // control doubleword indices
  localparam logic [1:0] UADM_WORD_CMD = 2'h0;
  localparam logic [1:0] UADM_WORD_LOG1 = 2'h1;
  localparam logic [1:0] UADM_WORD_ADR = 2'h2;
  localparam logic [1:0] UADM_WORD_LOG3 = 2'h3;
  // route one-hot: bit0 mux, bits 1..4 selector subchannels 1..4
  localparam int UADM_ROUTE_W = 5;
  localparam logic [4:0] UADM_ROUTE_NONE = 5'h00;
  localparam logic [4:0] UADM_ROUTE_MUX = 5'h01;
  // operation codes presented by the cpu
  typedef enum logic [1:0] {
    UADM_OP_START = 2'h0,
    UADM_OP_HALT = 2'h1,
    UADM_OP_TEST = 2'h2,
    UADM_OP_TEST_CHAN = 2'h3
  } uadm_op_t;
  // sequencer states
  typedef enum logic [4:0] {
    UADM_ST_IDLE = 5'h01,
    UADM_ST_REQ = 5'h02,
    UADM_ST_XFER = 5'h04,
    UADM_ST_LOG = 5'h08,
    UADM_ST_DONE = 5'h10
  } uadm_state_t;
endpackage

/* File: design/uadm_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module uadm_decode
  import uadm_pkg::*;
(
  // address in
  input wire logic [7:0] unit_addr,
  input wire logic [3:0] burst_present,
  input wire logic [3:0] burst_test_mode,
  // decode out
  output logic [4:0] route,
  output logic is_sel,
  output logic [1:0] burst_idx,
  output logic [3:0] dev_num,
  output logic invalid
);
  always_comb begin
    is_sel = unit_addr[UADM_SEL_HI] & unit_addr[UADM_SEL_LO];
    burst_idx = unit_addr[UADM_BURST_HI:UADM_BURST_LO];
    dev_num = unit_addr[UADM_DEV_HI:UADM_DEV_LO];
    route = UADM_ROUTE_MUX;
    invalid = 1'b0;
    if (is_sel) begin
      route = 5'(5'h02 << burst_idx);
      invalid = ~burst_present[burst_idx] | burst_test_mode[burst_idx];
    end
  end
endmodule
`default_nettype wire

/* File: design/uadm_top.sv */
`timescale 1ns/1ps
`default_nettype none
module uadm_top
  import uadm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // cpu instruction
  input wire logic cpu_valid,
  input wire logic [1:0] cpu_op,
  input wire logic [7:0] unit_addr,
  input wire logic logout_req,
  input wire logic [3:0] burst_present,
  input wire logic [3:0] burst_test_mode,
  // priority network
  input wire logic [3:0] burst_req,
  // local store write data
  input wire logic [71:0] ls_wdata,
  // outputs
  output logic cpu_accept,
  output logic cpu_reject,
  output logic busy,
  output logic [4:0] route,
  output logic [3:0] dev_num,
  output logic [3:0] burst_resp,
  output logic [9:0] ls_addr,
  output logic ls_we,
  output logic [71:0] ls_rdata,
  output logic done
);
  // ----------------------------------------
  // address decode
  // ----------------------------------------
  logic [4:0] dec_route;
  logic dec_sel;
  logic [1:0] dec_idx;
  logic [3:0] dec_dev;
  logic dec_inv;

  uadm_decode u_dec (
    .unit_addr(unit_addr),
    .burst_present(burst_present),
    .burst_test_mode(burst_test_mode),
    .route(dec_route),
    .is_sel(dec_sel),
    .burst_idx(dec_idx),
    .dev_num(dec_dev),
    .invalid(dec_inv)
  );

  // ----------------------------------------
  // local storage
  // ----------------------------------------
  // flip-flop storage; large, but each device keeps a private group
  logic [71:0] ls_mem_q [UADM_LS_DEPTH];

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  uadm_state_t st_q, st_d;
  logic [7:0] ua_q, ua_d;
  logic sel_q, sel_d;
  logic [1:0] mod_q, mod_d;
  logic logout_q, logout_d;
  logic [4:0] route_q, route_d;
  logic [3:0] dev_q, dev_d;
  logic acc_q, acc_d, rej_q, rej_d, done_q, done_d, we_q, we_d;
  logic [3:0] resp_q, resp_d;
  logic [9:0] la_q, la_d;
  logic [71:0] rd_q, rd_d;
  logic [3:0] grant;
  logic busy_q, busy_d;

  // fixed priority, lowest subchannel wins
  always_comb begin
    grant = 4'h0;
    for (int i = UADM_NSEL - 1; i >= 0; i--) begin
      if (burst_req[i]) begin
        grant = 4'h0;
        grant[i] = 1'b1;
      end
    end
  end

  always_comb begin
    st_d = st_q;
    ua_d = ua_q;
    sel_d = sel_q;
    mod_d = mod_q;
    logout_d = logout_q;
    route_d = route_q;
    dev_d = dev_q;
    acc_d = 1'b0;
    rej_d = 1'b0;
    done_d = 1'b0;
    we_d = 1'b0;
    resp_d = 4'h0;
    la_d = la_q;
    rd_d = rd_q;
    case (st_q)
      UADM_ST_IDLE: begin
        if (cpu_valid) begin
          if (dec_inv) begin
            rej_d = 1'b1;
          end else begin
            acc_d = 1'b1;
            ua_d = unit_addr;
            sel_d = dec_sel;
            route_d = dec_route;
            dev_d = dec_dev;
            logout_d = logout_req;
            mod_d = UADM_WORD_CMD;
            st_d = (dec_sel && !logout_req) ? UADM_ST_REQ : (logout_req ? UADM_ST_LOG : UADM_ST_XFER);
          end
        end
      end
      UADM_ST_REQ: begin
        // the subchannel waits here until its own response comes back
        resp_d = grant;
        if (grant[ua_q[UADM_BURST_HI:UADM_BURST_LO]]) begin
          st_d = UADM_ST_XFER;
        end
      end
      UADM_ST_XFER: begin
        la_d = {ua_q, mod_q};
        rd_d = ls_mem_q[{ua_q, mod_q}];
        we_d = 1'b1;
        if (sel_q) begin
          // selector devices touch only words 0 and 2
          if (mod_q == UADM_WORD_CMD) begin
            mod_d = UADM_WORD_ADR;
          end else begin
            st_d = UADM_ST_DONE;
          end
        end else begin
          mod_d = mod_q + 2'h1;
          if (mod_q == UADM_WORD_LOG3) begin
            st_d = UADM_ST_DONE;
          end
        end
      end
      UADM_ST_LOG: begin
        la_d = {ua_q, mod_q};
        // old contents come back here too, as on a normal transfer
        rd_d = ls_mem_q[{ua_q, mod_q}];
        we_d = 1'b1;
        mod_d = mod_q + 2'h1;
        if (mod_q == UADM_WORD_LOG3) begin
          st_d = UADM_ST_DONE;
        end
      end
      UADM_ST_DONE: begin
        done_d = 1'b1;
        route_d = UADM_ROUTE_NONE;
        st_d = UADM_ST_IDLE;
      end
      default: begin
        st_d = UADM_ST_IDLE;
      end
    endcase
    busy_d = (st_d != UADM_ST_IDLE);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= UADM_ST_IDLE;
      ua_q <= 8'h00;
      sel_q <= 1'b0;
      mod_q <= 2'h0;
      logout_q <= 1'b0;
      route_q <= UADM_ROUTE_NONE;
      dev_q <= 4'h0;
      acc_q <= 1'b0;
      rej_q <= 1'b0;
      done_q <= 1'b0;
      we_q <= 1'b0;
      resp_q <= 4'h0;
      la_q <= 10'h000;
      rd_q <= 72'h0;
      busy_q <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
      ua_q <= ua_d;
      sel_q <= sel_d;
      mod_q <= mod_d;
      logout_q <= logout_d;
      route_q <= route_d;
      dev_q <= dev_d;
      acc_q <= acc_d;
      rej_q <= rej_d;
      done_q <= done_d;
      we_q <= we_d;
      resp_q <= resp_d;
      la_q <= la_d;
      rd_q <= rd_d;
      busy_q <= busy_d;
    end
  end

  // store array has no reset; contents are undefined until written
  always_ff @(posedge clock) begin
    if (clk_en && !rst && we_d) begin
      ls_mem_q[la_d] <= ls_wdata;
    end
  end

  assign cpu_accept = acc_q;
  assign cpu_reject = rej_q;
  assign busy = busy_q;
  assign route = route_q;
  assign dev_num = dev_q;
  assign burst_resp = resp_q;
  assign ls_addr = la_q;
  assign ls_we = we_q;
  assign ls_rdata = rd_q;
  assign done = done_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_route_onehot;
    @(posedge clock) disable iff (rst) (route_q != UADM_ROUTE_NONE) |-> $onehot(route_q);
  endproperty
  a_route_onehot: assert property (p_route_onehot) else $error("route not one-hot");

  property p_mux_low;
    @(posedge clock) disable iff (rst)
      (clk_en && st_q == UADM_ST_IDLE && cpu_valid && unit_addr <= UADM_MUX_LAST) |=> route_q == UADM_ROUTE_MUX;
  endproperty
  a_mux_low: assert property (p_mux_low) else $error("low address not on shared path");

  property p_sel_range;
    @(posedge clock) disable iff (rst)
      (clk_en && st_q == UADM_ST_IDLE && cpu_valid && !dec_inv && unit_addr >= UADM_SEL_FIRST)
      |=> route_q == 5'(5'h02 << $past(unit_addr[5:4]));
  endproperty
  a_sel_range: assert property (p_sel_range) else $error("selector range misrouted");

  property p_dev;
    @(posedge clock) disable iff (rst) (clk_en && acc_d) |=> dev_q == $past(unit_addr[3:0]);
  endproperty
  a_dev: assert property (p_dev) else $error("device number wrong");

  property p_invalid;
    @(posedge clock) disable iff (rst)
      (clk_en && st_q == UADM_ST_IDLE && cpu_valid && dec_sel && burst_test_mode[dec_idx]) |=> cpu_reject && !cpu_accept;
  endproperty
  a_invalid: assert property (p_invalid) else $error("test-mode subchannel accepted");

  property p_resp_wait;
    @(posedge clock) disable iff (rst) (st_q == UADM_ST_XFER && sel_q && !logout_q && $changed(st_q)) |-> $past(st_q) == UADM_ST_REQ;
  endproperty
  a_resp_wait: assert property (p_resp_wait) else $error("transfer before priority response");

  property p_resp_onehot;
    @(posedge clock) disable iff (rst) $onehot0(resp_q);
  endproperty
  a_resp_onehot: assert property (p_resp_onehot) else $error("multiple responses");

  property p_lsaddr;
    @(posedge clock) disable iff (rst) ls_we |-> ls_addr[9:2] == ua_q;
  endproperty
  a_lsaddr: assert property (p_lsaddr) else $error("store address not unit address");

  property p_sel_words;
    @(posedge clock) disable iff (rst) (ls_we && sel_q && !logout_q) |-> ls_addr[0] == 1'b0;
  endproperty
  a_sel_words: assert property (p_sel_words) else $error("selector used odd word");

  property p_log_len;
    @(posedge clock) disable iff (rst)
      (clk_en && acc_d && logout_req) |=> ##1 (clk_en && ls_we) [*4];
  endproperty
  a_log_len: assert property (p_log_len) else $error("logout not four words");

  c_mux: cover property (@(posedge clock) cpu_accept && route == UADM_ROUTE_MUX);
  c_sel4: cover property (@(posedge clock) cpu_accept && route == 5'h10);
  c_rej: cover property (@(posedge clock) cpu_reject);
  c_done: cover property (@(posedge clock) done);
endmodule
`default_nettype wire

/* File: tb/uadm_cu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far side: a subchannel asks for the shared lines once it is routed
module uadm_cu_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // from the channel
  input wire logic [4:0] route,
  input wire logic [3:0] resp,
  input wire logic [1:0] lat,
  // to the channel
  output logic [3:0] req
);
  logic [3:0] served_q;
  logic [1:0] cnt_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      req <= 4'h0;
      served_q <= 4'h0;
      cnt_q <= 2'h0;
    end else begin
      // lat stretches the wait so slow requesters are exercised too
      cnt_q <= (|route[4:1] && !(|served_q) && cnt_q != 2'h3) ? cnt_q + 2'h1 : cnt_q;
      if (!(|route[4:1])) cnt_q <= 2'h0;
      for (int i = 0; i < 4; i++) begin
        if (resp[i]) begin
          req[i] <= 1'b0;
          served_q[i] <= 1'b1;
        end else if (route[i+1] && !served_q[i] && cnt_q >= lat) begin
          req[i] <= 1'b1;
        end
        if (!route[i+1]) begin
          req[i] <= 1'b0;
          served_q[i] <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import uadm_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cpu_valid = 1'b0;
  logic [1:0] cpu_op = 2'h0;
  logic [7:0] unit_addr = 8'h00;
  logic logout_req = 1'b0;
  logic [3:0] present = 4'hf;
  logic [3:0] tmode = 4'h0;
  logic [3:0] noise = 4'h0;
  logic [1:0] lat = 2'h0;
  logic cen = 1'b1;
  logic [71:0] wdata = 72'h0;
  logic [3:0] mreq;
  logic accept, reject, busy, ls_we, done;
  logic [4:0] route;
  logic [3:0] dev, resp;
  logic [9:0] ls_addr;
  logic [71:0] rdata;
  logic [71:0] shadow [logic [9:0]];
  logic [31:0] rs = 32'h000064ff;
  int fail_count = 0;
  int checks = 0;
  logic [7:0] corners [11] = '{8'h00, 8'hbf, 8'hc0, 8'hcf, 8'hd0, 8'hdf, 8'he0, 8'hef, 8'hf0, 8'hff, 8'hc0};

  always #50 clock = ~clock;

  uadm_top uut (.clock(clock), .rst(rst), .clk_en(cen), .cpu_valid(cpu_valid), .cpu_op(cpu_op),
    .unit_addr(unit_addr), .logout_req(logout_req), .burst_present(present), .burst_test_mode(tmode),
    .burst_req(mreq | noise), .ls_wdata(wdata), .cpu_accept(accept), .cpu_reject(reject),
    .busy(busy), .route(route), .dev_num(dev), .burst_resp(resp), .ls_addr(ls_addr),
    .ls_we(ls_we), .ls_rdata(rdata), .done(done));

  uadm_cu_model cu (.clock(clock), .rst(rst), .route(route), .resp(resp), .lat(lat), .req(mreq));

  // ----------------
  // helpers
  // ----------------
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic chk(string n, logic [71:0] e, logic [71:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic tick;
    @(posedge clock);
    #1;
  endtask

  // one instruction from request to the idle cycle after done
  task automatic run_op(logic [7:0] a, logic lg);
    logic sel, ok, gr;
    logic [4:0] er;
    int n;
    sel = a[7:6] == 2'b11;
    ok = !sel || (present[a[5:4]] && !tmode[a[5:4]]);
    er = sel ? 5'h01 << (a[5:4] + 1) : 5'h01;
    gr = !sel || lg;
    n = 0;
    rs = xs(rs);
    wdata = {rs, rs, rs[7:0]};
    lat = rs[9:8];
    noise = rs[13:10] & {4{sel & !lg}};
    unit_addr = a;
    logout_req = lg;
    cpu_op = rs[15:14];
    cpu_valid = 1'b1;
    tick;
    cpu_valid = 1'b0;
    chk("accept", ok, accept);
    chk("reject", !ok, reject);
    if (ok) begin
      chk("route", er, route);
      if (sel) chk("dev_num", a[3:0], dev);
      if (sel) chk("cu number", a[UADM_CU_BIT], dev[UADM_CU_BIT]);
      if (sel) chk("unit in cu", a[2:0], dev[2:0]);
      for (int c = 0; c < 40 && done !== 1'b1; c++) begin
        tick;
        if (resp !== 4'h0) chk("grant one-hot", 1'b1, $onehot(resp));
        if (sel && resp[a[5:4]] === 1'b1) gr = 1'b1;
        noise &= ~resp;
        if (ls_we === 1'b1) begin
          chk("write after grant", 1'b1, gr);
          chk("route held", er, route);
          chk("ls_addr", {a, (sel && !lg) ? {n[0], 1'b0} : n[1:0]}, ls_addr);
          if (shadow.exists(ls_addr)) chk("ls_rdata", shadow[ls_addr], rdata);
          shadow[ls_addr] = wdata;
          n++;
        end
      end
      chk("done", 1'b1, done);
      chk("word count", (sel && !lg) ? 2 : 4, n);
    end
    tick;
    chk("route idle", 5'h00, route);
    noise = 4'h0;
    $display("test %h logout %b done", a, lg);
  endtask

  // ----------------
  // main sequence
  // ----------------
  initial begin
    repeat (3) @(posedge clock);
    #1;
    rst = 1'b0;
    chk("reset route", 5'h00, route);
    chk("reset busy", 1'b0, busy);
    foreach (corners[i]) run_op(corners[i], 1'b0);
    // a request while the enable is low must leave the sequencer idle
    cen = 1'b0;
    unit_addr = 8'h10;
    cpu_valid = 1'b1;
    repeat (3) tick;
    chk("frozen accept", 1'b0, accept);
    chk("frozen busy", 1'b0, busy);
    cpu_valid = 1'b0;
    cen = 1'b1;
    tick;
    present = 4'hd;
    run_op(8'hd5, 1'b0);
    present = 4'hf;
    tmode = 4'h8;
    run_op(8'hf3, 1'b0);
    tmode = 4'h0;
    run_op(8'he7, 1'b1);
    run_op(8'h40, 1'b1);
    repeat (60) begin
      rs = xs(rs);
      present = rs[23:20] | rs[19:16];
      tmode = rs[15:12] & rs[11:8];
      run_op(rs[7:0], rs[24] & rs[25]);
    end
    give_verdict;
  end

  initial begin
    #2000000;
    fail_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
